/* File: verilog/timer01_map.svh */
// Register offsets, field positions, reset values and timing counts of the timer block
`ifndef TIMER01_MAP_SVH
`define TIMER01_MAP_SVH

// Byte addresses on the APB
`define TCTL_ADDR 8'h88
`define TMODE_ADDR 8'h89
`define T0LO_ADDR 8'h8a
`define T1LO_ADDR 8'h8b
`define T0HI_ADDR 8'h8c
`define T1HI_ADDR 8'h8d
`define VEC_ADDR 8'h90
`define ISTAT_ADDR 8'h94
`define IMASK_ADDR 8'h98

// Control register bit positions
`define B_TF1 7
`define B_TR1 6
`define B_TF0 5
`define B_TR0 4
`define B_IE1 3
`define B_IT1 2
`define B_IE0 1
`define B_IT0 0

// Mode register bit positions (per timer nibble)
`define B_GATE 3
`define B_SRC 2

// Vector acknowledge bits
`define V_T0 0
`define V_X0 1
`define V_T1 2
`define V_X1 3

// Reset values
`define CTL_RST 8'h00
`define MODE_RST 8'h00
`define ZERO8 8'h00

// Timer prescale: count once every this many system clocks
`define TICK_DIV 2
`define PRESC_MAX 5'h1f

`endif

/* File: verilog/timer01_pkg.sv */
// Types shared by the timer block
package timer01_pkg;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } tmode_t;

    // Per-timer mode nibble
    typedef struct packed {
        logic gate;
        logic src;
        tmode_t mode;
    } tcfg_t;

    // Sticky event bits: overflow 0/1, ext int 0/1
    typedef struct packed {
        logic x1;
        logic t1;
        logic x0;
        logic t0;
    } evt_t;

endpackage

/* File: verilog/timer01_control_ext_int.sv */
// Two timer/counters with external interrupt flags, reached over APB
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "timer01_map.svh"
// ===========================================================================
// Operation
// - Timer 1 overflow sets its flag, which clears when the CPU vectors to it.
// - Timer 1 counts only while its run bit is 1 and holds otherwise.
// - Timer 0 overflow sets its flag, which clears when the CPU vectors to it.
// - Timer 0 counts only while its run bit is 1 and holds otherwise; in mode 11 its high byte follows timer 1 run bit.
// - A falling edge on interrupt 1 pin sets its flag, cleared on vectoring in edge mode only.
// - Interrupt 1 type bit picks low level (0) or falling edge (1).
// - A falling edge on interrupt 0 pin sets its flag, cleared on vectoring in edge mode only.
// - Interrupt 0 type bit picks low level (0) or falling edge (1).
// - With timer 1 gate set, timer 1 runs only while run bit and pin 1 are high.
// - Timer 1 in timer mode advances once every 2 system clocks.
// - Timer 1 in counter mode advances on each falling edge of its count pin.
// - Timer 1 mode: 13-bit, 16-bit, 8-bit auto-reload, or stopped.
// - Timer 0 shares modes 00-10; in 11 its high byte uses timer 1 run and flag.
// - With timer 0 gate set, timer 0 runs only while run bit and pin 0 are high.
// - Timer 0 source bit picks 2-clock timer or count-pin falling edges.
// ===========================================================================
module timer01_control_ext_int
    import timer01_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic xint0_pin,
    input wire logic xint1_pin,
    input wire logic t0_count_pin,
    input wire logic t1_count_pin,
    // CPU interrupt lines
    output logic xint0_req,
    output logic xint1_req,
    output logic t0_req,
    output logic t1_req,
    output logic irq
);

    // =======================================================================
    // Pin synchronisers
    // =======================================================================
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;
    wire [3:0] pins_raw = {t1_count_pin, t0_count_pin, xint1_pin, xint0_pin};

    // Two stages, third stage only for edge detect
    // Reset to the idle high level of the pins, so no false fall follows reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 4'hf;
            sync2_q <= 4'hf;
            sync3_q <= 4'hf;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Third stage compares with the second; nothing else reads the first stage
    wire [3:0] fall = sync3_q & ~sync2_q; // One pulse per fall
    wire x0_lvl = sync2_q[0];
    wire x1_lvl = sync2_q[1];

    // =======================================================================
    // Registers
    // =======================================================================
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [7:0] mode_q;
    logic [7:0] t0lo_q;
    logic [7:0] t0lo_d;
    logic [7:0] t0hi_q;
    logic [7:0] t0hi_d;
    logic [7:0] t1lo_q;
    logic [7:0] t1lo_d;
    logic [7:0] t1hi_q;
    logic [7:0] t1hi_d;
    logic presc_q;
    evt_t ist_q;
    evt_t ist_d;
    evt_t imask_q;

    wire tcfg_t cfg0 = tcfg_t'(mode_q[3:0]);
    wire tcfg_t cfg1 = tcfg_t'(mode_q[7:4]);

    // =======================================================================
    // APB decode
    // =======================================================================
    // Gating with pready keeps a transfer in the cycle after reset from landing
    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    // Read data is loaded at the end of the setup cycle, so it stands at the access edge
    wire rd_setup = psel & ~penable & ~pwrite;
    wire hit_ctl = paddr == `TCTL_ADDR;
    wire hit_mode = paddr == `TMODE_ADDR;
    wire hit_t0lo = paddr == `T0LO_ADDR;
    wire hit_t1lo = paddr == `T1LO_ADDR;
    wire hit_t0hi = paddr == `T0HI_ADDR;
    wire hit_t1hi = paddr == `T1HI_ADDR;
    wire hit_vec = paddr == `VEC_ADDR;
    wire hit_ist = paddr == `ISTAT_ADDR;
    wire hit_imask = paddr == `IMASK_ADDR;
    // Unmapped addresses read as zero and raise pslverr
    wire hit_any = hit_ctl | hit_mode | hit_t0lo | hit_t1lo | hit_t0hi | hit_t1hi
        | hit_vec | hit_ist | hit_imask;
    wire [7:0] wd = pwdata[7:0];
    // Vector acknowledge stands in for the CPU entering a service routine
    wire [3:0] vec_ack = (wr & hit_vec) ? pwdata[3:0] : 4'h0;
    // Next values of the plain software registers
    wire [7:0] mode_d = (wr & hit_mode) ? wd : mode_q;
    wire evt_t imask_d = (wr & hit_imask) ? evt_t'(wd[3:0]) : imask_q;

    // =======================================================================
    // Count enables
    // =======================================================================
    // Free-running divider: the first tick after a run bit is set may come a clock late
    wire tick = presc_q; // Every second system clock

    wire run0 = ctl_q[`B_TR0] & (~cfg0.gate | x0_lvl);
    wire run1 = ctl_q[`B_TR1] & (~cfg1.gate | x1_lvl);
    // Count pins must stay low and high one clock each; faster pulses are lost
    wire src0 = cfg0.src ? fall[2] : tick;
    wire src1 = cfg1.src ? fall[3] : tick;
    wire inc0 = run0 & src0;
    wire inc1 = run1 & src1 & (cfg1.mode != MODE_SPLIT); // Mode 11 stops
    // Split mode: high byte of timer 0 ticks on timer 1's run bit
    wire inc0h = ctl_q[`B_TR1] & tick;

    // =======================================================================
    // Counter next-state and overflow
    // =======================================================================
    logic ovf0;
    logic ovf1;
    logic ovf0h;

    // Timer 0 counting
    always_comb begin
        t0lo_d = t0lo_q;
        t0hi_d = t0hi_q;
        ovf0 = 1'b0;
        ovf0h = 1'b0;
        case (cfg0.mode)
            MODE_13BIT: begin
                if (inc0) begin
                    t0lo_d = (t0lo_q[4:0] == `PRESC_MAX) ? `ZERO8 : t0lo_q + 8'h01;
                    if (t0lo_q[4:0] == `PRESC_MAX) begin
                        t0hi_d = t0hi_q + 8'h01;
                        ovf0 = &t0hi_q;
                    end
                end
            end
            MODE_16BIT: begin
                if (inc0) begin
                    {t0hi_d, t0lo_d} = {t0hi_q, t0lo_q} + 16'h0001;
                    ovf0 = &{t0hi_q, t0lo_q};
                end
            end
            MODE_RELOAD: begin
                if (inc0) begin
                    ovf0 = &t0lo_q;
                    t0lo_d = ovf0 ? t0hi_q : t0lo_q + 8'h01;
                end
            end
            MODE_SPLIT: begin
                if (inc0) begin
                    t0lo_d = t0lo_q + 8'h01;
                    ovf0 = &t0lo_q;
                end
                if (inc0h) begin
                    t0hi_d = t0hi_q + 8'h01;
                    ovf0h = &t0hi_q;
                end
            end
            default: begin
                t0lo_d = t0lo_q;
            end
        endcase
        if (wr & hit_t0lo) t0lo_d = wd;
        if (wr & hit_t0hi) t0hi_d = wd;
    end

    // Timer 1 counting
    always_comb begin
        t1lo_d = t1lo_q;
        t1hi_d = t1hi_q;
        ovf1 = 1'b0;
        case (cfg1.mode)
            MODE_13BIT: begin
                if (inc1) begin
                    t1lo_d = (t1lo_q[4:0] == `PRESC_MAX) ? `ZERO8 : t1lo_q + 8'h01;
                    if (t1lo_q[4:0] == `PRESC_MAX) begin
                        t1hi_d = t1hi_q + 8'h01;
                        ovf1 = &t1hi_q;
                    end
                end
            end
            MODE_16BIT: begin
                if (inc1) begin
                    {t1hi_d, t1lo_d} = {t1hi_q, t1lo_q} + 16'h0001;
                    ovf1 = &{t1hi_q, t1lo_q};
                end
            end
            MODE_RELOAD: begin
                if (inc1) begin
                    ovf1 = &t1lo_q;
                    t1lo_d = ovf1 ? t1hi_q : t1lo_q + 8'h01;
                end
            end
            default: begin
                t1lo_d = t1lo_q; // Stopped, value held
            end
        endcase
        if (wr & hit_t1lo) t1lo_d = wd;
        if (wr & hit_t1hi) t1hi_d = wd;
    end

    // =======================================================================
    // Control register flags
    // =======================================================================
    // Edge mode latches falls; level mode follows the low pin
    wire x0_set = ctl_q[`B_IT0] ? fall[0] : ~x0_lvl;
    wire x1_set = ctl_q[`B_IT1] ? fall[1] : ~x1_lvl;
    // Timer 1 overflow still reaches the flag in split mode; software stops timer 1
    wire t1_set = ovf1 | ovf0h; // Split mode borrows timer 1 flag

    // Software write first, then vector clears, then hardware sets win
    always_comb begin
        ctl_d = (wr & hit_ctl) ? wd : ctl_q;
        if (vec_ack[`V_T0]) ctl_d[`B_TF0] = 1'b0;
        if (vec_ack[`V_T1]) ctl_d[`B_TF1] = 1'b0;
        if (vec_ack[`V_X0] & ctl_q[`B_IT0]) ctl_d[`B_IE0] = 1'b0;
        if (vec_ack[`V_X1] & ctl_q[`B_IT1]) ctl_d[`B_IE1] = 1'b0;
        if (ovf0) ctl_d[`B_TF0] = 1'b1;
        if (t1_set) ctl_d[`B_TF1] = 1'b1;
        if (x0_set) ctl_d[`B_IE0] = 1'b1;
        if (x1_set) ctl_d[`B_IE1] = 1'b1;
        // Level mode: flag mirrors pin, so it drops when the pin returns high
        if (!ctl_q[`B_IT0] && x0_lvl && !(wr & hit_ctl)) ctl_d[`B_IE0] = 1'b0;
        if (!ctl_q[`B_IT1] && x1_lvl && !(wr & hit_ctl)) ctl_d[`B_IE1] = 1'b0;
    end

    // Sticky status, cleared by reading it; new events win over the read
    always_comb begin
        ist_d = (rd & hit_ist) ? evt_t'(4'h0) : ist_q;
        if (ovf0) ist_d.t0 = 1'b1;
        if (x0_set) ist_d.x0 = 1'b1;
        if (t1_set) ist_d.t1 = 1'b1;
        if (x1_set) ist_d.x1 = 1'b1;
    end

    // =======================================================================
    // Read data
    // =======================================================================
    // Next-state values: the word loaded at the setup edge is what the registers
    // hold through the access cycle, and the status clear at the access edge keeps
    // any event that arrives after the capture
    wire [7:0] rsel =
        hit_ctl ? ctl_d :
        hit_mode ? mode_d :
        hit_t0lo ? t0lo_d :
        hit_t1lo ? t1lo_d :
        hit_t0hi ? t0hi_d :
        hit_t1hi ? t1hi_d :
        hit_ist ? {4'h0, ist_d} :
        hit_imask ? {4'h0, imask_d} : `ZERO8;
    wire [31:0] prdata_d = rd_setup ? {24'h000000, rsel} : prdata;

    // =======================================================================
    // State registers
    // =======================================================================
    // Timer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= 1'b0;
            t0lo_q <= `ZERO8;
            t0hi_q <= `ZERO8;
            t1lo_q <= `ZERO8;
            t1hi_q <= `ZERO8;
        end else begin
            presc_q <= ~presc_q;
            t0lo_q <= t0lo_d;
            t0hi_q <= t0hi_d;
            t1lo_q <= t1lo_d;
            t1hi_q <= t1hi_d;
        end
    end

    // Control, mode and interrupt registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= `CTL_RST;
            mode_q <= `MODE_RST;
            ist_q <= evt_t'(4'h0);
            imask_q <= evt_t'(4'h0);
        end else begin
            ctl_q <= ctl_d;
            mode_q <= mode_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
        end
    end

    // Outputs, all registered; zero-wait slave so pready stays high
    // Request lines follow the next flag state, so they match the control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            xint0_req <= 1'b0;
            xint1_req <= 1'b0;
            t0_req <= 1'b0;
            t1_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            prdata <= prdata_d;
            pready <= 1'b1;
            pslverr <= psel & ~penable & ~hit_any;
            xint0_req <= ctl_d[`B_IE0];
            xint1_req <= ctl_d[`B_IE1];
            t0_req <= ctl_d[`B_TF0];
            t1_req <= ctl_d[`B_TF1];
            irq <= |(ist_d & imask_d);
        end
    end

endmodule

/* File: test/timer01_pin_model.sv */
// Pin-side model: interrupt and count pins driven towards the block
`timescale 1ns/1ps
module timer01_pin_model (
    // Clock
    input wire logic pclk,
    // Pins towards the block
    output logic xint0_pin,
    output logic xint1_pin,
    output logic t0_count_pin,
    output logic t1_count_pin
);
    // ===========================================================
    // Pin drivers
    // Pins idle high, as with a pull-up on each line
    logic [3:0] pins = 4'hf;
    assign {t1_count_pin, t0_count_pin, xint1_pin, xint0_pin} = pins;
    // Each level is held 4 edges so the 2-flop synchroniser sees it
    task automatic drive(input int i, input logic v);
        @(posedge pclk);
        pins[i] <= v;
        repeat (4) @(posedge pclk);
    endtask
    // One full low pulse: exactly one falling transition
    task automatic fall(input int i);
        drive(i, 1'b0);
        drive(i, 1'b1);
    endtask
endmodule

/* File: test/timer01_control_ext_int_checker.sv */
// Concurrent checks on the ports of the timer block
`timescale 1ns/1ps
`include "timer01_map.svh"
module timer01_control_ext_int_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and request lines
    input wire logic xint0_pin,
    input wire logic xint1_pin,
    input wire logic xint0_req,
    input wire logic xint1_req,
    input wire logic t0_req,
    input wire logic t1_req
);
    // ===========================================================
    // Helpers
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped, wr_acc, rd_setup;
    assign mapped = paddr inside {[`TCTL_ADDR:`T1HI_ADDR], `VEC_ADDR, `ISTAT_ADDR, `IMASK_ADDR};
    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    sequence s_bad; psel && !penable && !mapped ##1 psel && penable; endsequence
    sequence s_good; psel && !penable && mapped ##1 psel && penable; endsequence
    sequence s_x0_low; $fell(xint0_pin) ##1 !xint0_pin [*3]; endsequence
    sequence s_x1_low; $fell(xint1_pin) ##1 !xint1_pin [*3]; endsequence
    // ===========================================================
    // Bus behaviour
    a_pready_high: assert property ($past(presetn) |-> pready)
        else $error("pready low after reset");
    a_err_unmapped: assert property (s_bad |-> pslverr)
        else $error("pslverr missing on unmapped access");
    a_ok_mapped: assert property (s_good |-> !pslverr)
        else $error("pslverr on mapped access");
    a_err_single: assert property (pslverr |=> !pslverr)
        else $error("pslverr longer than one cycle");
    a_rdata_upper: assert property (prdata[31:8] == 24'h0)
        else $error("prdata upper bits not zero");
    a_rdata_hold: assert property (!$past(rd_setup) |-> $stable(prdata))
        else $error("prdata changed without a read");
    // ===========================================================
    // Flags
    a_x0_flag_set: assert property (s_x0_low |-> ##[0:3] xint0_req)
        else $error("interrupt 0 flag not set");
    a_x1_flag_set: assert property (s_x1_low |-> ##[0:3] xint1_req)
        else $error("interrupt 1 flag not set");
    a_t0_flag_kept: assert property ($fell(t0_req) |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("timer 0 flag cleared without a write");
    a_t1_flag_kept: assert property ($fell(t1_req) |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("timer 1 flag cleared without a write");
endmodule

bind timer01_control_ext_int timer01_control_ext_int_checker timer01_control_ext_int_checker_inst (.*);

/* File: test/timer01_control_ext_int_tb.sv */
// Self-checking bench for the timer and external interrupt block
`timescale 1ns/1ps
`include "timer01_map.svh"
module timer01_control_ext_int_tb;
    import timer01_pkg::*;
    // ===========================================================
    // Signals
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rv = 0;
    logic [7:0] paddr = 8'h00, r, rdat;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, x0p, x1p, c0p, c1p, x0r, x1r, t0r, t1r, irq;
    evt_t reqs;
    logic [4:0] outs;
    int failures = 0, tests_run = 0, waited;
    logic [7:0] exp_q[$];
    assign reqs = {x1r, t1r, x0r, t0r};
    assign outs = {irq, reqs};
    always #20 pclk = ~pclk;
    timer01_control_ext_int timer01_control_ext_int_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .xint0_pin(x0p),
        .xint1_pin(x1p), .t0_count_pin(c0p), .t1_count_pin(c1p), .xint0_req(x0r),
        .xint1_req(x1r), .t0_req(t0r), .t1_req(t1r), .irq(irq));
    timer01_pin_model timer01_pin_model_inst (.pclk(pclk), .xint0_pin(x0p),
        .xint1_pin(x1p), .t0_count_pin(c0p), .t1_count_pin(c1p));
    // ===========================================================
    // Tasks
    task automatic close_out();
        $display("Counts: %0d checks, %0d failures", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Bus master; pready is waited for under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic c);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'($urandom()), d}; // Upper bits random, the block must ignore them
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            if (++n > 50) begin
                failures++;
                close_out();
            end
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        rdat <= prdata[7:0]; // Taken at the edge where pready is high
        rv <= c;
        @(posedge pclk);
        rv <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 8'h00, 1'b1);
    endtask
    // Waits at falling edges, away from the flops' own edge
    task automatic wait_out(input int i, input logic v, input int hi);
        for (waited = 0; outs[i] !== v; waited++) begin
            if (waited == hi) begin
                failures++;
                close_out();
            end
            @(negedge pclk);
        end
        chk("request line", {7'h0, v}, {7'h0, outs[i]});
        @(posedge pclk);
    endtask
    task automatic endt(input string s);
        $display("Test %s done, failures %0d", s, failures);
    endtask
    // Read data against the oldest note
    always @(negedge pclk)
        if (rv)
            chk("prdata", exp_q.pop_front(), rdat);
    // ===========================================================
    // Main sequence
    initial begin
        void'($urandom(20595));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++)
            rd(`TCTL_ADDR + 8'(i), 8'h00);
        wr(`TCTL_ADDR, 8'ha5);
        rd(`TCTL_ADDR, 8'ha5);
        wr(`VEC_ADDR, 8'h05);
        rd(`TCTL_ADDR, 8'h05);
        r = 8'($urandom());
        wr(`T0LO_ADDR, r);
        wr(8'ha0, r);
        repeat (10) @(posedge pclk);
        rd(`T0LO_ADDR, r);
        rd(8'ha0, 8'h00);
        endt("registers");
        // 32 ticks to overflow at one tick per two clocks
        wr(`T0HI_ADDR, 8'hff);
        wr(`T0LO_ADDR, 8'he0);
        wr(`TMODE_ADDR, 8'h01);
        wr(`TCTL_ADDR, 8'h15);
        wait_out(0, 1'b1, 100);
        chk("tick cycles", 8'h01, {7'h0, waited > 58 && waited < 68});
        rd(`TCTL_ADDR, 8'h35);
        wr(`TCTL_ADDR, 8'h05);
        wr(`TMODE_ADDR, 8'h09);
        wr(`T0LO_ADDR, 8'hff);
        wr(`T0HI_ADDR, 8'hff);
        timer01_pin_model_inst.drive(0, 1'b0);
        wr(`TCTL_ADDR, 8'h15);
        repeat (20) @(posedge pclk);
        wait_out(0, 1'b0, 1);
        timer01_pin_model_inst.drive(0, 1'b1);
        wait_out(0, 1'b1, 20);
        endt("timer 0");
        wr(`TCTL_ADDR, 8'h05);
        wr(`TMODE_ADDR, 8'h50);
        wr(`T1LO_ADDR, 8'hfe);
        wr(`T1HI_ADDR, 8'hff);
        wr(`TCTL_ADDR, 8'h45);
        repeat (20) @(posedge pclk);
        timer01_pin_model_inst.fall(3);
        wait_out(2, 1'b0, 1);
        timer01_pin_model_inst.fall(3);
        wait_out(2, 1'b1, 10);
        rd(`T1LO_ADDR, 8'h00);
        wr(`TCTL_ADDR, 8'h05);
        wr(`TMODE_ADDR, 8'h60);
        wr(`T1HI_ADDR, 8'hf0);
        wr(`T1LO_ADDR, 8'hff);
        wr(`TCTL_ADDR, 8'h45);
        timer01_pin_model_inst.fall(3);
        wait_out(2, 1'b1, 10);
        rd(`T1LO_ADDR, 8'hf0);
        wr(`TCTL_ADDR, 8'h05);
        wr(`TMODE_ADDR, 8'h74);
        wr(`T1LO_ADDR, 8'h00);
        wr(`T0LO_ADDR, 8'h1f);
        wr(`T0HI_ADDR, 8'hff);
        wr(`TCTL_ADDR, 8'h55);
        timer01_pin_model_inst.fall(3);
        timer01_pin_model_inst.fall(2);
        wait_out(0, 1'b1, 10);
        rd(`T1LO_ADDR, 8'h00);
        wr(`TCTL_ADDR, 8'h05);
        wr(`TMODE_ADDR, 8'h03);
        wr(`T0HI_ADDR, 8'hff);
        wr(`TCTL_ADDR, 8'h45);
        wait_out(2, 1'b1, 10);
        wait_out(0, 1'b0, 1);
        endt("modes");
        // Interrupt 0 level, interrupt 1 edge; only interrupt 1 unmasked
        wr(`TCTL_ADDR, 8'h04);
        apb(1'b0, `ISTAT_ADDR, 8'h00, 1'b0);
        wr(`IMASK_ADDR, 8'h08);
        timer01_pin_model_inst.drive(0, 1'b0);
        wait_out(1, 1'b1, 10);
        wait_out(4, 1'b0, 1);
        timer01_pin_model_inst.drive(0, 1'b1);
        wait_out(1, 1'b0, 10);
        timer01_pin_model_inst.fall(1);
        wait_out(3, 1'b1, 1);
        wait_out(4, 1'b1, 3);
        wr(`VEC_ADDR, 8'h08);
        rd(`TCTL_ADDR, 8'h04);
        rd(`ISTAT_ADDR, 8'h0a);
        wait_out(4, 1'b0, 3);
        wr(`TCTL_ADDR, 8'h01);
        timer01_pin_model_inst.fall(0);
        wait_out(1, 1'b1, 1);
        timer01_pin_model_inst.drive(1, 1'b0);
        wait_out(3, 1'b1, 10);
        endt("external interrupts");
        close_out();
    end
endmodule
